// *** inc/ccar_pkg.sv ***
// Shared constants and types for the charge counter register block
package ccar_pkg;
    // Bus address and register subaddresses
    localparam logic [6:0] I2C_ADDR = 7'h64;
    localparam logic [7:0] SUB_CFG = 8'h01;
    localparam logic [7:0] SUB_THR = 8'h02;
    localparam logic [7:0] SUB_CHG = 8'h03;
    localparam logic [7:0] SUB_STAT = 8'h04;
    localparam logic [7:0] SUB_INT = 8'h05;
    // Values after reset
    localparam logic [7:0] CFG_RST = 8'h00;
    localparam logic [7:0] THR_RST = 8'hFF;
    localparam logic [2:0] STAT_RST = 3'h0;
    // Field positions
    localparam int CFG_OVR_BIT = 7;
    localparam int CFG_OUT_HI = 6;
    localparam int CFG_OUT_LO = 4;
    localparam int CFG_M_HI = 3;
    localparam int INT_CLR_BIT = 0;
    localparam int INT_TEST_BIT = 1;
    localparam int ST_ONTIME = 0;
    localparam int ST_CNTOVF = 1;
    localparam int ST_ALARM = 2;
    // Counter chain geometry
    localparam int ACC_BITS = 8;
    localparam int RIP_BITS = 42;
    // Interrupt release window after a clear
    localparam int CLK_NS = 40;
    localparam int RELEASE_NS = 1000;
    localparam int RELEASE_CYC = RELEASE_NS / CLK_NS;
    localparam int REL_W = 5;
    // Byte roles inside one bus transfer
    localparam logic [1:0] ROLE_ADDR = 2'h0;
    localparam logic [1:0] ROLE_SUB = 2'h1;
    localparam logic [1:0] ROLE_DATA = 2'h2;
    // Bus slave states
    typedef enum logic [4:0] {
        S_IDLE = 5'h01,
        S_RECV = 5'h02,
        S_ACK = 5'h04,
        S_SEND = 5'h08,
        S_RACK = 5'h10
    } ccar_state_t;
endpackage

// *** logic/ccar_sync.sv ***
// Two flip-flop synchroniser for a vector of pin inputs
module ccar_sync #(
    parameter int W = 1
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    // First and second stage
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } ccar_sync_t;
    ccar_sync_t r;
    ccar_sync_t nx;

    // Shift one stage per clock
    always_comb
    begin
        nx.s1 = d_i;
        nx.s2 = r.s1;
    end

    // State registers
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            r <= '0;
        else
            r <= nx;
    end

    assign q_o = r.s2;
endmodule

// *** logic/ccar_chain.sv ***
// Accumulator plus ripple counter chain with prescaled readable window
module ccar_chain import ccar_pkg::*; #(
    parameter int ACC_W = ACC_BITS,
    parameter int RIP_W = RIP_BITS
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic pulse_i,
    input wire logic [ACC_W-1:0] meas_i,
    input wire logic [3:0] m_i,
    input wire logic wr_i,
    input wire logic [7:0] wr_data_i,
    output logic [7:0] window_o,
    output logic ripple_tgl_o,
    output logic ovf_o,
    output logic eval_o
);
    localparam int CW = ACC_W + RIP_W;
    localparam int SW = CW + 1;
    // Chain, window copy, ripple clock toggle, strobes
    typedef struct packed {
        logic [CW-1:0] chain;
        logic [7:0] win;
        logic tgl;
        logic ovf;
        logic eval;
    } ccar_chain_t;
    ccar_chain_t r;
    ccar_chain_t nx;
    logic [SW-1:0] sum;
    logic [SW-1:0] lim;
    logic [ACC_W:0] lsum;
    logic [CW-1:0] wmask;
    logic [6:0] base;

    // Add one measurement, detect carry and overflow, apply host write
    always_comb
    begin
        nx = r;
        nx.ovf = 1'b0;
        nx.eval = 1'b0;
        base = 7'(RIP_W) - 7'(m_i);
        lim = SW'(1) << (7'(CW) - 7'(m_i));
        lsum = {1'b0, r.chain[ACC_W-1:0]} + {1'b0, meas_i};
        sum = {1'b0, r.chain} + SW'(meas_i);
        wmask = CW'(8'hFF) << base;
        if (pulse_i)
        begin
            // Adder carry clocks the ripple part
            if (lsum[ACC_W])
                nx.tgl = ~r.tgl; // R16
            // Bits above the prescaled window mean overflow
            if (sum >= lim)
            begin
                nx.ovf = 1'b1; // R8
                nx.chain = CW'(sum & (lim - SW'(1)));
            end
            else
                nx.chain = CW'(sum); // R20
            nx.eval = 1'b1; // R15
        end
        // Host overwrites only the readable bits
        if (wr_i)
        begin
            nx.chain = (nx.chain & ~wmask) | (CW'(wr_data_i) << base); // R6
            nx.eval = 1'b1; // R15
        end
        nx.win = 8'(nx.chain >> base); // R5 R19
    end

    // State registers, cleared only by the supply reset
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            r <= '0; // R17
        else
            r <= nx;
    end

    assign window_o = r.win;
    assign ripple_tgl_o = r.tgl;
    assign ovf_o = r.ovf;
    assign eval_o = r.eval;

    // Host write lands in the window
    a_window_write: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        wr_i && !pulse_i && $stable(m_i) |=> window_o == $past(wr_data_i)) // R6
        else $error("window not loaded by host write");
    // No pulse and no write keeps the chain unchanged
    a_chain_hold: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        !pulse_i && !wr_i |=> r.chain == $past(r.chain)) // R18
        else $error("chain changed while idle");
endmodule

// *** logic/ccar_top.sv ***
// Charge counter register bank with bus slave and alarm interrupt
// Contract
// R1: Five byte registers at subaddresses one to five
// R2: Config low nibble holds prescale M, reset zero
// R3: Config bits 6..4 override pins when bit7
// R4: Threshold register holds alarm level, resets FFh
// R5: Charge register reads top eight chain bits
// R6: Host write overwrites readable chain bits
// R7: Status bit0 flags on-time measurement overflow
// R8: Status bit1 flags ripple counter overflow
// R9: Status bit2 when window reaches threshold
// R10: Any fault drives interrupt low
// R11: Clear bit releases interrupt, then self-clears
// R12: Pending alarm: release 1us, clear bit drops
// R13: On-time fault waits for next pulse
// R14: Counter overflow returns until lowered and rescaled
// R15: Threshold checked only after pulse or write
// R16: Test bit routes ripple clock to interrupt
// R17: Supply reset clears registers and chain
// R18: Disabled converter holds all state
// R19: LSB weight divides by two to M
// R20: Eight-bit adds feed 42-bit ripple counter
// R21: Interrupt active low, idles high
// R22: Slave only at address 1100100
// R23: Sleeping converter leaves counter unchanged
// R24: Write: addr, sub, data; read via restart
// R25: Unused control bits ignored, status pads zero
module ccar_top import ccar_pkg::*; (
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic conv_en_i,
    input wire logic charge_pulse_i,
    input wire logic [7:0] charge_meas_i,
    input wire logic charge_pulse_on_time_ovf_i,
    input wire logic [2:0] out_pins_i,
    output logic [2:0] out_sel_o,
    output logic irq_n_o
);
    // ------------------------------------------------------------
    // Reset release and pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] rst_pipe; // Reset release stages
    logic rst_n; // Synchronous-release reset
    logic [15:0] pins_s; // Synchronised pin vector
    logic scl_s;
    logic sda_s;
    logic en_s;
    logic pulse_s;
    logic ot_s;
    logic [2:0] outp_s;
    logic [7:0] meas_s;

    // Release reset two clocks after the pin rises
    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
            rst_pipe <= 2'h0;
        else
            rst_pipe <= {rst_pipe[0], 1'b1};
    end
    assign rst_n = rst_pipe[1];

    ccar_sync #(.W(16)) u_sync (
        .clock_i(clock_i),
        .rst_n_i(rst_n),
        .d_i({scl_i, sda_i, conv_en_i, charge_pulse_i, charge_pulse_on_time_ovf_i,
              out_pins_i, charge_meas_i}),
        .q_o(pins_s)
    );
    assign {scl_s, sda_s, en_s, pulse_s, ot_s, outp_s, meas_s} = pins_s;

    // ------------------------------------------------------------
    // Block state
    // ------------------------------------------------------------
    typedef struct packed {
        ccar_state_t st; // Bus slave state
        logic [1:0] role; // Meaning of the byte being received
        logic [3:0] cnt; // Bit counter
        logic [7:0] sh; // Shift register
        logic [7:0] sub; // Current subaddress
        logic rw; // Read direction
        logic oe; // Data line pulled low
        logic lvl; // Level driven on the data line
        logic scl_q; // Previous clock level
        logic sda_q; // Previous data level
        logic [7:0] cfg; // output_and_prescale_config
        logic [7:0] thr; // alarm_threshold
        logic e_clr; // Clear request bit
        logic e_test; // Counter test bit
        logic wc_stb; // Charge register write strobe
        logic [7:0] wc_data; // Charge register write data
        logic pls_stb; // Accepted charge pulse
        logic [7:0] meas_q; // Measurement taken with the pulse
        logic ot_q; // On-time overflow seen with the pulse
        logic pulse_q; // Previous pulse level
        logic [2:0] flags; // fault_status bits
        logic ovf_lat; // Counter overflow still standing
        logic c_low; // Charge lowered since overflow
        logic m_chg; // Prescale changed since overflow
        logic [REL_W-1:0] rel; // Release window counter
        logic [2:0] out_sel; // Effective output select
        logic irq_n; // Interrupt pin level
    } ccar_top_t;
    ccar_top_t r;
    ccar_top_t nx;

    logic [7:0] win; // Readable chain window
    logic tgl; // Ripple clock toggle
    logic c_ovf; // Chain overflow strobe
    logic c_eval; // Threshold evaluation strobe
    logic scl_r; // Clock rising
    logic scl_f; // Clock falling
    logic start_c; // Start or repeated start
    logic stop_c; // Stop
    logic [7:0] rdat; // Byte returned on a read
    logic [2:0] set_f; // Flag set requests
    logic clr_f; // Flag clear request

    // ------------------------------------------------------------
    // Charge counter chain
    // ------------------------------------------------------------
    ccar_chain u_chain (
        .clock_i(clock_i),
        .rst_n_i(rst_n),
        .pulse_i(r.pls_stb),
        .meas_i(r.meas_q),
        .m_i(r.cfg[CFG_M_HI:0]),
        .wr_i(r.wc_stb),
        .wr_data_i(r.wc_data),
        .window_o(win),
        .ripple_tgl_o(tgl),
        .ovf_o(c_ovf),
        .eval_o(c_eval)
    );

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb
    begin
        nx = r;
        nx.scl_q = scl_s;
        nx.sda_q = sda_s;
        nx.lvl = 1'b0;
        nx.wc_stb = 1'b0;
        set_f = 3'h0;
        clr_f = 1'b0;
        // Bus line events
        scl_r = scl_s & ~r.scl_q;
        scl_f = ~scl_s & r.scl_q;
        start_c = scl_s & r.scl_q & r.sda_q & ~sda_s;
        stop_c = scl_s & r.scl_q & ~r.sda_q & sda_s;
        // Read-back mux, write-only registers read zero
        if (r.sub == SUB_CHG)
            rdat = win; // R5
        else if (r.sub == SUB_STAT)
            rdat = {5'h00, r.flags}; // R25
        else
            rdat = 8'h00; // R1

        // Charge pulses counted only while converter runs
        nx.pulse_q = pulse_s;
        nx.pls_stb = pulse_s & ~r.pulse_q & en_s; // R18 R23
        nx.meas_q = meas_s;
        nx.ot_q = ot_s;
        if (pulse_s & ~r.pulse_q & en_s & ot_s)
            set_f[ST_ONTIME] = 1'b1; // R7 R13

        // Bus slave sequencing
        unique case (r.st)
            S_IDLE:
            begin
                nx.oe = 1'b0;
            end
            S_RECV:
            begin
                if (scl_r)
                begin
                    nx.sh = {r.sh[6:0], sda_s};
                    nx.cnt = r.cnt + 4'h1;
                end
                else if (scl_f && r.cnt == 4'h8)
                begin
                    nx.cnt = 4'h0;
                    nx.st = S_ACK;
                    nx.oe = 1'b1;
                    if (r.role == ROLE_ADDR)
                    begin
                        // Only our fixed address is answered
                        nx.rw = r.sh[0];
                        if (r.sh[7:1] != I2C_ADDR)
                        begin
                            nx.st = S_IDLE; // R22
                            nx.oe = 1'b0;
                        end
                    end
                    else if (r.role == ROLE_SUB)
                        nx.sub = r.sh; // R24
                    else
                    begin
                        // Register writes
                        unique case (r.sub)
                            SUB_CFG:
                            begin
                                if (r.sh[CFG_M_HI:0] != r.cfg[CFG_M_HI:0])
                                    nx.m_chg = 1'b1; // R14
                                nx.cfg = r.sh; // R2 R3
                            end
                            SUB_THR: nx.thr = r.sh; // R4
                            SUB_CHG:
                            begin
                                nx.wc_stb = 1'b1; // R6
                                nx.wc_data = r.sh;
                                if (r.sh < win)
                                    nx.c_low = 1'b1; // R14
                            end
                            SUB_INT:
                            begin
                                nx.e_test = r.sh[INT_TEST_BIT]; // R16 R25
                                if (r.sh[INT_CLR_BIT])
                                begin
                                    nx.e_clr = 1'b1; // R11
                                    clr_f = 1'b1;
                                    nx.rel = REL_W'(RELEASE_CYC); // R12
                                end
                            end
                            default: ; // Read-only or unmapped
                        endcase
                    end
                end
            end
            S_ACK:
            begin
                if (scl_f)
                begin
                    nx.cnt = 4'h0;
                    if (r.rw)
                    begin
                        // Read: present the addressed register
                        nx.st = S_SEND; // R24
                        nx.sh = rdat;
                        nx.oe = ~rdat[7];
                    end
                    else
                    begin
                        nx.st = S_RECV;
                        nx.oe = 1'b0;
                        nx.role = (r.role == ROLE_ADDR) ? ROLE_SUB : ROLE_DATA;
                    end
                end
            end
            S_SEND:
            begin
                if (scl_r)
                    nx.cnt = r.cnt + 4'h1;
                else if (scl_f && r.cnt == 4'h8)
                begin
                    nx.oe = 1'b0;
                    nx.st = S_RACK;
                end
                else if (scl_f)
                begin
                    nx.sh = {r.sh[6:0], 1'b0};
                    nx.oe = ~r.sh[6];
                end
            end
            S_RACK:
            begin
                // Single-byte read ends at the master's acknowledge
                if (scl_r)
                    nx.st = S_IDLE;
            end
        endcase
        // Start and stop override any state
        if (start_c)
        begin
            nx.st = S_RECV;
            nx.role = ROLE_ADDR;
            nx.cnt = 4'h0;
            nx.oe = 1'b0;
        end
        else if (stop_c)
        begin
            nx.st = S_IDLE;
            nx.oe = 1'b0;
        end

        // Threshold compared only on pulse or charge write
        if (c_eval && win >= r.thr)
            set_f[ST_ALARM] = 1'b1; // R9 R15
        // Counter overflow stands until charge lowered and rescaled
        if (c_ovf)
        begin
            set_f[ST_CNTOVF] = 1'b1; // R8
            nx.ovf_lat = 1'b1;
            nx.c_low = 1'b0;
            nx.m_chg = 1'b0;
        end
        else if (nx.c_low && nx.m_chg)
            nx.ovf_lat = 1'b0; // R14
        // Release window runs down, then clear bit drops
        if (r.rel != '0 && !clr_f)
        begin
            nx.rel = r.rel - REL_W'(1);
            if (r.rel == REL_W'(1))
            begin
                nx.e_clr = 1'b0; // R11 R12
                if (r.ovf_lat)
                    set_f[ST_CNTOVF] = 1'b1; // R14
            end
        end
        // Set wins over clear
        nx.flags = (clr_f ? 3'h0 : r.flags) | set_f; // R10

        // Output select override
        nx.out_sel = nx.cfg[CFG_OVR_BIT] ? nx.cfg[CFG_OUT_HI:CFG_OUT_LO] : outp_s; // R3
        // Interrupt pin
        if (nx.e_test)
            nx.irq_n = tgl; // R16
        else if (nx.rel != '0)
            nx.irq_n = 1'b1; // R12 R13
        else
            nx.irq_n = ~|nx.flags; // R10 R21
    end

    // ------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------
    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            r <= '0; // R17
            r.st <= S_IDLE;
            r.scl_q <= 1'b1;
            r.sda_q <= 1'b1;
            r.cfg <= CFG_RST;
            r.thr <= THR_RST; // R4
            r.flags <= STAT_RST;
            r.irq_n <= 1'b1; // R21
        end
        else
            r <= nx;
    end

    assign sda_o = r.lvl;
    assign sda_oe_o = r.oe;
    assign out_sel_o = r.out_sel;
    assign irq_n_o = r.irq_n;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_n);

    sequence s_released;
        irq_n_o [*8];
    endsequence

    a_irq_state: assert property (!r.e_test |-> irq_n_o == (r.rel != '0 || r.flags == 3'h0)) // R10
        else $error("interrupt level disagrees with flags");
    a_clear_release: assert property ($rose(r.e_clr) && !r.e_test |-> s_released) // R12
        else $error("interrupt not released after clear");
    a_clear_self: assert property ($rose(r.e_clr) |-> r.e_clr [*8] ##[1:30] !r.e_clr) // R11
        else $error("clear bit did not return to zero");
    a_alarm_trip: assert property (c_eval && win >= r.thr |=> r.flags[ST_ALARM]) // R9
        else $error("threshold alarm missed");
    a_ontime_flag: assert property (r.pls_stb && r.ot_q |-> r.flags[ST_ONTIME]) // R7
        else $error("on-time overflow not flagged");
    a_cnt_ovf: assert property (c_ovf |=> r.flags[ST_CNTOVF] && r.ovf_lat) // R8
        else $error("counter overflow not flagged");
    a_out_override: assert property (1'b1 |=> out_sel_o == (r.cfg[CFG_OVR_BIT] ?
        r.cfg[CFG_OUT_HI:CFG_OUT_LO] : $past(outp_s))) // R3
        else $error("output select wrong");
    a_test_route: assert property (r.e_test && $past(r.e_test) |-> irq_n_o == $past(tgl)) // R16
        else $error("test mode not routing ripple clock");
    a_no_count_off: assert property (!en_s |=> !r.pls_stb) // R18
        else $error("pulse accepted while disabled");
    a_stop_release: assert property (stop_c |=> !sda_oe_o && r.st == S_IDLE) // R24
        else $error("data line held after stop");
endmodule

// *** verification/ccar_i2c_master.sv ***
// Bus master model issuing single-byte register transfers
module ccar_i2c_master import ccar_pkg::*; (
    input wire logic clock_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_oe_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Bus released at start; pull-up wins
    initial
    begin
        scl_o = 1'b1;
        sda_oe_o = 1'b0;
    end
    // Move only on falling clock edges
    task automatic wt(input int n);
        repeat (n) @(negedge clock_i);
    endtask
    // Data set mid-low, sampled late in high phase
    task automatic bit_io(input logic b, output logic s);
        wt(4);
        sda_oe_o = ~b;
        wt(4);
        scl_o = 1'b1;
        wt(8);
        s = sda_i;
        scl_o = 1'b0;
    endtask
    // Byte MSB first, then released acknowledge slot
    task automatic byte_io(input logic [7:0] d, output logic [7:0] q, output logic s);
        logic t;
        for (int i = 7; i >= 0; i--)
        begin
            bit_io(d[i], t);
            q[i] = t;
        end
        bit_io(1'b1, s);
    endtask
    // Start or repeated start: data falls with clock high
    task automatic start();
        wt(4);
        sda_oe_o = 1'b0;
        wt(4);
        scl_o = 1'b1;
        wt(8);
        sda_oe_o = 1'b1;
        wt(8);
        scl_o = 1'b0;
    endtask
    // Stop: data rises with clock high
    task automatic stop();
        wt(4);
        sda_oe_o = 1'b1;
        wt(4);
        scl_o = 1'b1;
        wt(8);
        sda_oe_o = 1'b0;
        wt(8);
    endtask
    // Write: address, subaddress, one data byte
    task automatic wr(input logic [6:0] a, input logic [7:0] sub, input logic [7:0] d,
        output logic nak);
        logic [7:0] q;
        logic s0, s1, s2;
        start();
        byte_io({a, 1'b0}, q, s0);
        byte_io(sub, q, s1);
        byte_io(d, q, s2);
        stop();
        nak = s0 | s1 | s2;
    endtask
    // Read: subaddress, repeated start, one byte, master nack
    task automatic rd(input logic [7:0] sub, output logic [7:0] q, output logic nak);
        logic [7:0] t;
        logic s0, s1, s2, s3;
        start();
        byte_io({I2C_ADDR, 1'b0}, t, s0);
        byte_io(sub, t, s1);
        start();
        byte_io({I2C_ADDR, 1'b1}, t, s2);
        byte_io(8'hFF, q, s3);
        stop();
        nak = s0 | s1 | s2;
    endtask
endmodule

// *** verification/test_coulomb_counter_alarm_regs.sv ***
// Self-checking bench for the charge counter register block
module test_coulomb_counter_alarm_regs import ccar_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock_i = 1'b0;
    logic nrst_i = 1'b0;
    logic conv_en = 1'b1;
    logic chg_pulse = 1'b0;
    logic [7:0] meas = 8'h00;
    logic on_ovf = 1'b0;
    logic [2:0] pins = 3'h0;
    logic [2:0] out_sel;
    logic irq_n, irq_q, s_o, s_oe, scl, m_oe, nak;
    logic [7:0] q, v, t, acc;
    logic [3:0] m;
    // Data wire: pulled up unless a party pulls low
    wire sda = (s_oe ? s_o : 1'b1) & ~m_oe;
    int n_mismatch = 0;
    int checks_done = 0;
    int cyc = 0;
    int tgl = 0;
    int hi_run = 0;
    int last_hi = 0;
    int carries = 0;
    int c0, t0;
    always #20 clock_i = ~clock_i;
    ccar_top dut (.clock_i(clock_i), .nrst_i(nrst_i), .scl_i(scl), .sda_i(sda),
        .sda_o(s_o), .sda_oe_o(s_oe), .conv_en_i(conv_en), .charge_pulse_i(chg_pulse),
        .charge_meas_i(meas), .charge_pulse_on_time_ovf_i(on_ovf), .out_pins_i(pins),
        .out_sel_o(out_sel), .irq_n_o(irq_n));
    ccar_i2c_master m0 (.clock_i(clock_i), .sda_i(sda), .scl_o(scl), .sda_oe_o(m_oe));
    // Verdict and end of run
    task automatic end_of_test();
        if (n_mismatch == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Ceiling about 2.7 times the expected run; edge count; high-run length
    always @(posedge clock_i)
    begin
        cyc++;
        if (irq_n !== irq_q)
            tgl++;
        irq_q <= irq_n;
        if (irq_n === 1'b1)
            hi_run++;
        else
        begin
            if (hi_run != 0)
                last_hi = hi_run;
            hi_run = 0;
        end
        if (cyc == 60000)
        begin
            n_mismatch++;
            end_of_test();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic put(input logic [7:0] sub, input logic [7:0] d);
        m0.wr(I2C_ADDR, sub, d, nak);
        chk({7'h00, nak}, 8'h00);
    endtask
    task automatic get(input logic [7:0] sub, input logic [7:0] e);
        m0.rd(sub, q, nak);
        chk({7'h00, nak}, 8'h00);
        chk(q, e);
    endtask
    // Window read at prescale sh of a value written at zero
    function automatic logic [7:0] exp_win(input logic [7:0] val, input logic [3:0] sh);
        return val << sh;
    endfunction
    function automatic int carry_of(input logic [7:0] a, input logic [7:0] d);
        return (a + d) > 255;
    endfunction
    // One charge transfer; model adder tracks carries
    task automatic pulse(input logic [7:0] d, input logic ov);
        @(negedge clock_i);
        meas = d;
        on_ovf = ov;
        repeat (2) @(negedge clock_i);
        chg_pulse = 1'b1;
        repeat (4) @(negedge clock_i);
        chg_pulse = 1'b0;
        repeat (6) @(negedge clock_i);
        if (conv_en)
        begin
            carries += carry_of(acc, d);
            acc = acc + d;
        end
    endtask
    initial
    begin
        acc = 8'h00;
        v = 8'($urandom(91));
        repeat (10) @(negedge clock_i);
        nrst_i = 1'b1;
        repeat (8) @(negedge clock_i);
        chk({7'h00, irq_n}, 8'h01);
        get(SUB_CHG, 8'h00);
        get(SUB_STAT, 8'h00);
        get(SUB_CFG, 8'h00);
        get(8'h09, 8'h00);
        m0.wr(7'h65, SUB_THR, 8'h00, nak);
        chk({7'h00, nak}, 8'h01);
        // Prescale moves the readable window
        v = 8'($urandom_range(254, 1));
        m = 4'($urandom_range(7, 1));
        put(SUB_CHG, v);
        put(SUB_CFG, {4'h0, m});
        get(SUB_CHG, exp_win(v, m));
        put(SUB_CFG, 8'h00);
        get(SUB_CHG, v);
        put(SUB_CHG, 8'h00);
        // Select override against pins
        pins = 3'($urandom);
        t = 8'($urandom);
        repeat (8) @(negedge clock_i);
        chk({5'h00, out_sel}, {5'h00, pins});
        put(SUB_CFG, {1'b1, t[2:0], 4'h0});
        pins = ~pins;
        repeat (8) @(negedge clock_i);
        chk({5'h00, out_sel}, {5'h00, t[2:0]});
        put(SUB_CFG, {1'b0, t[2:0], 4'h0});
        repeat (8) @(negedge clock_i);
        chk({5'h00, out_sel}, {5'h00, pins});
        // Counter check mode: one edge per carry
        put(SUB_INT, 8'h02);
        repeat (4) @(negedge clock_i);
        c0 = carries;
        t0 = tgl;
        for (int i = 0; i < 12; i++)
            pulse(8'($urandom), 1'b0);
        chk(8'(tgl - t0), 8'(carries - c0));
        put(SUB_INT, 8'h00);
        // Disabled converter ignores pulses
        conv_en = 1'b0;
        pulse(8'hFF, 1'b1);
        get(SUB_STAT, 8'h00);
        get(SUB_CHG, 8'h00);
        conv_en = 1'b1;
        // On-time fault, then clear with a fresh fault inside the window
        pulse(8'h00, 1'b1);
        chk({7'h00, irq_n}, 8'h00);
        get(SUB_STAT, 8'h01);
        fork
            put(SUB_INT, 8'h01);
            begin
                repeat (443) @(negedge clock_i);
                pulse(8'h00, 1'b1);
            end
        join
        chk({7'h00, last_hi inside {[24:26]}}, 8'h01);
        chk({7'h00, irq_n}, 8'h00);
        put(SUB_INT, 8'h01);
        repeat (60) @(negedge clock_i);
        chk({7'h00, irq_n}, 8'h01);
        get(SUB_STAT, 8'h00);
        // Threshold alarm, evaluated only on write or pulse
        put(SUB_CHG, 8'hFE);
        get(SUB_STAT, 8'h00);
        t = 8'($urandom_range(240, 16));
        put(SUB_THR, t);
        put(SUB_CHG, t - 8'h01);
        get(SUB_STAT, 8'h00);
        put(SUB_CHG, t);
        get(SUB_STAT, 8'h04);
        chk({7'h00, irq_n}, 8'h00);
        put(SUB_INT, 8'hFC);
        chk({7'h00, irq_n}, 8'h00);
        put(SUB_INT, 8'h01);
        repeat (60) @(negedge clock_i);
        chk({7'h00, irq_n}, 8'h01);
        pulse(8'h00, 1'b0);
        chk({7'h00, irq_n}, 8'h00);
        get(SUB_STAT, 8'h04);
        // Counter overflow repeats until lowered and rescaled
        put(SUB_CHG, 8'hFF);
        put(SUB_CFG, 8'h0F);
        pulse(8'h00, 1'b0);
        get(SUB_STAT, 8'h06);
        put(SUB_INT, 8'h01);
        get(SUB_STAT, 8'h02);
        chk({7'h00, irq_n}, 8'h00);
        put(SUB_CHG, 8'h05);
        put(SUB_CHG, 8'h00);
        put(SUB_CFG, 8'h00);
        put(SUB_INT, 8'h01);
        chk({7'h00, irq_n}, 8'h01);
        end_of_test();
    end
endmodule
